/* File: core/car_defines.svh */
// Register offsets, field positions and sizes of the abort/remote/filter block
`ifndef CAR_DEFINES_SVH
`define CAR_DEFINES_SVH
`define CAR_OFS_CTRL     8'h00
`define CAR_OFS_FEN      8'h04
`define CAR_OFS_MSID     8'h08
`define CAR_OFS_MEID     8'h0c
`define CAR_OFS_STAT     8'h10
`define CAR_OFS_TXB      8'h20
`define CAR_OFS_PTR      8'h40
`define CAR_OFS_FSID     8'h80
`define CAR_OFS_FEID     8'hc0
`define CAR_BIT_ABORT    12
`define CAR_BIT_TXSEL    7
`define CAR_BIT_BUFFER_SEND_REQUEST    3
`define CAR_BIT_AUTO_REMOTE_REPLY_FLAG    2
`define CAR_NUM_FILT     16
`define CAR_NUM_TXB      8
`define CAR_PTR_FIFO     4'hf
`define CAR_REC_SHIFT    3
`define CAR_RST_FEN      16'h0000
`endif

/* File: core/car_pkg.sv */
// Types shared by the abort/remote/filter block
package car_pkg;
    typedef struct packed {
        logic [10:0] sid;
        logic [17:0] eid;
        logic        ide;
        logic        rtr;
    } car_frame_t;

    typedef struct packed {
        logic [1:0] pri;
        logic       txsel;
        logic       auto_remote_reply_flag;
        logic       req;
    } car_txbuf_t;

    typedef enum logic [1:0] {RX_IDLE, RX_CMP, RX_DMA} car_rx_state_t;

    typedef struct packed {
        logic                    ack;
        logic [31:0]             rdat;
        logic                    abort;
        logic [15:0]             fen;
        logic [10:0]             msid;
        logic [17:0]             meid;
        logic [15:0][10:0]       fsid;
        logic [15:0][17:0]       feid;
        logic [15:0][3:0]        fptr;
        car_txbuf_t [7:0]        txb;
        logic                    busy;
        logic [2:0]              busy_buf;
        logic                    txv;
        logic [2:0]              txbuf;
        car_frame_t              asm_fr;
        car_rx_state_t           rxst;
        logic                    dreq;
        logic [3:0]              dbuf;
        logic [3:0]              dhit;
        logic                    ovr;
    } car_state_t;
endpackage

/* File: core/car_filter_match.sv */
// Compares an assembled identifier against all acceptance filters
`timescale 1ns/1ps
`default_nettype none
`include "car_defines.svh"
module car_filter_match (
    input  wire car_pkg::car_frame_t fr,
    input  wire logic [15:0]         fen,
    input  wire logic [10:0]         msid,
    input  wire logic [17:0]         meid,
    input  wire logic [15:0][10:0]   fsid,
    input  wire logic [15:0][17:0]   feid,
    output logic                     hit,
    output logic [3:0]               idx
);
    import car_pkg::*;

    // Zero mask bits always match
    function automatic logic bits_ok(input logic [17:0] m, input logic [17:0] f,
                                     input logic [17:0] x);
        return ((m & (f ^ x)) == 18'h00000);
    endfunction

    always_comb begin
        logic ok;
        ok  = 1'b0;
        hit = 1'b0;
        idx = 4'h0;
        for (int i = `CAR_NUM_FILT - 1; i >= 0; i--) begin
            ok = bits_ok({7'h00, msid}, {7'h00, fsid[i]}, {7'h00, fr.sid}) &&
                 (!fr.ide || bits_ok(meid, feid[i], fr.eid));
            if (ok && fen[i]) begin
                hit = 1'b1;
                idx = 4'(i);
            end
        end
    end
endmodule
`default_nettype wire

/* File: core/car_core.sv */
// Transmit abort, auto remote reply and receive acceptance filtering
//
// Overview of operation
// - Abort-all cancels every pending send request
// - Software clearing send request drops that buffer
// - Frames already on the bus still complete
// - Remote frame: RTR recessive, zero data length
// - Remote frames in standard and extended format
// - Only buffers 0-7 answer remote requests
// - Transmit-buffer pointer only serves remote replies
// - Matched remote frame sets buffer send request
// - Standard and extended frames moved automatically
// - Received record is eight words, transmit layout
// - Frame assembled, then checked against 16 filters
// - Compare 11-bit, plus 18-bit when extended
// - Full match raises DMA transfer request
// - Per-filter enable bit at filter index
// - Each filter has standard and extended registers
// - Successful transmission clears send request
// - Zero mask bit always matches
// - Pointer 0-14 selects buffer, 15 the FIFO
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "car_defines.svh"
module car_core (
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic [31:0]              wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic                rx_valid,
    input  wire car_pkg::car_frame_t rx_frame,
    input  wire logic                tx_start,
    input  wire logic [2:0]          tx_start_buf,
    input  wire logic                tx_done,
    output logic                     tx_req_valid,
    output logic [2:0]               tx_req_buf,
    output logic                     dma_req,
    output logic [3:0]               dma_buf,
    output logic [3:0]               dma_hit,
    output logic [6:0]               dma_addr,
    input  wire logic                dma_ack
);
    import car_pkg::*;

    car_state_t q;
    car_state_t d;
    logic       hit;
    logic [3:0] idx;
    logic [3:0] ptr;
    logic       to_txb;
    logic       auto_rep;
    logic       bus_req;

    // Highest user priority wins, higher index breaks ties
    function automatic logic [3:0] pick(input car_txbuf_t [7:0] b);
        logic [3:0] r;
        logic [1:0] bp;
        r  = 4'h0;
        bp = 2'h0;
        for (int i = 0; i < `CAR_NUM_TXB; i++) begin
            if (b[i].req && b[i].txsel && (!r[3] || b[i].pri >= bp)) begin
                r  = {1'b1, 3'(i)};
                bp = b[i].pri;
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] txb_word(input car_txbuf_t b);
        logic [31:0] w;
        w = 32'h00000000;
        w[1:0] = b.pri;
        w[`CAR_BIT_TXSEL] = b.txsel;
        w[`CAR_BIT_AUTO_REMOTE_REPLY_FLAG] = b.auto_remote_reply_flag;
        w[`CAR_BIT_BUFFER_SEND_REQUEST] = b.req;
        return w;
    endfunction

    car_filter_match u_match (
        .fr   (q.asm_fr),
        .fen  (q.fen),
        .msid (q.msid),
        .meid (q.meid),
        .fsid (q.fsid),
        .feid (q.feid),
        .hit  (hit),
        .idx  (idx)
    );

    assign ptr      = q.fptr[idx];
    // Low pointers on tx-selected buffers reply only
    assign to_txb   = !ptr[3] && q.txb[ptr[2:0]].txsel;
    assign auto_rep = to_txb && q.asm_fr.rtr && q.txb[ptr[2:0]].auto_remote_reply_flag;
    assign bus_req  = wb_cyc_i && wb_stb_i && !q.ack;

    always_comb begin
        logic [7:0] a;
        a   = wb_adr_i;
        d   = q;
        d.ack = bus_req;
        // Register reads, unmapped offsets read zero
        if (bus_req && !wb_we_i) begin
            d.rdat = 32'h00000000;
            if (a == `CAR_OFS_CTRL)
                d.rdat[`CAR_BIT_ABORT] = q.abort;
            else if (a == `CAR_OFS_FEN)
                d.rdat[15:0] = q.fen;
            else if (a == `CAR_OFS_MSID)
                d.rdat[10:0] = q.msid;
            else if (a == `CAR_OFS_MEID)
                d.rdat[17:0] = q.meid;
            else if (a == `CAR_OFS_STAT)
                d.rdat[13:0] = {q.ovr, q.dreq, q.busy, q.busy_buf,
                                q.txv, q.txbuf, q.rxst, 2'b00};
            else if (a[7:5] == 3'b001 && a[1:0] == 2'b00)
                d.rdat = txb_word(q.txb[a[4:2]]);
            else if (a[7:4] == 4'h4 && a[1:0] == 2'b00)
                d.rdat[15:0] = q.fptr[a[3:2]*4 +: 4];
            else if (a[7:6] == 2'b10 && a[1:0] == 2'b00)
                d.rdat[10:0] = q.fsid[a[5:2]];
            else if (a[7:6] == 2'b11 && a[1:0] == 2'b00)
                d.rdat[17:0] = q.feid[a[5:2]];
        end
        // Register writes, low three lanes carry all fields
        if (bus_req && wb_we_i && wb_sel_i[0] && a[1:0] == 2'b00) begin
            if (a == `CAR_OFS_CTRL && wb_sel_i[1])
                d.abort = d.abort | wb_dat_i[`CAR_BIT_ABORT];
            else if (a == `CAR_OFS_FEN && wb_sel_i[1])
                d.fen = wb_dat_i[15:0];
            else if (a == `CAR_OFS_MSID && wb_sel_i[1])
                d.msid = wb_dat_i[10:0];
            else if (a == `CAR_OFS_MEID && wb_sel_i[2:1] == 2'b11)
                d.meid = wb_dat_i[17:0];
            else if (a == `CAR_OFS_STAT)
                d.ovr = d.ovr & !wb_dat_i[13];
            else if (a[7:5] == 3'b001) begin
                d.txb[a[4:2]].pri   = wb_dat_i[1:0];
                d.txb[a[4:2]].txsel = wb_dat_i[`CAR_BIT_TXSEL];
                d.txb[a[4:2]].auto_remote_reply_flag = wb_dat_i[`CAR_BIT_AUTO_REMOTE_REPLY_FLAG];
                // Clear ignored for the frame on the bus
                if (!(q.busy && q.busy_buf == a[4:2]) ||
                    wb_dat_i[`CAR_BIT_BUFFER_SEND_REQUEST])
                    d.txb[a[4:2]].req = wb_dat_i[`CAR_BIT_BUFFER_SEND_REQUEST];
            end else if (a[7:4] == 4'h4 && wb_sel_i[1])
                d.fptr[a[3:2]*4 +: 4] = wb_dat_i[15:0];
            // Standard and extended match values per filter
            else if (a[7:6] == 2'b10 && wb_sel_i[1])
                d.fsid[a[5:2]] = wb_dat_i[10:0];
            else if (a[7:6] == 2'b11 && wb_sel_i[2:1] == 2'b11)
                d.feid[a[5:2]] = wb_dat_i[17:0];
        end
        // Abort all except the frame in flight
        if (q.abort) begin
            for (int i = 0; i < `CAR_NUM_TXB; i++)
                if (!(q.busy && q.busy_buf == 3'(i)))
                    d.txb[i].req = 1'b0;
            if (!q.busy)
                d.abort = 1'b0;
        end
        // Engine starts only a buffer still pending after this cycle's edits
        if (tx_start && !q.busy && d.txb[tx_start_buf].req) begin
            d.busy     = 1'b1;
            d.busy_buf = tx_start_buf;
        end
        if (tx_done && q.busy) begin
            d.busy = 1'b0;
            d.txb[q.busy_buf].req = 1'b0;
        end
        unique case (q.rxst)
            RX_IDLE: begin
                if (rx_valid) begin
                    d.asm_fr = rx_frame;
                    d.rxst   = RX_CMP;
                end
            end
            RX_CMP: begin
                d.rxst = RX_IDLE;
                if (hit && auto_rep)
                    // Queue stored data frame, set wins
                    d.txb[ptr[2:0]].req = 1'b1;
                else if (hit && !to_txb) begin
                    d.dreq = 1'b1;
                    d.dbuf = ptr;
                    d.dhit = idx;
                    d.rxst = RX_DMA;
                end
            end
            RX_DMA: begin
                if (dma_ack) begin
                    d.dreq = 1'b0;
                    d.rxst = RX_IDLE;
                end
            end
            default: d.rxst = RX_IDLE;
        endcase
        if (rx_valid && q.rxst != RX_IDLE)
            d.ovr = 1'b1;
        // Replies and software requests share one selection
        {d.txv, d.txbuf} = pick(d.txb);
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            q      <= '0;
            q.fen  <= `CAR_RST_FEN;
            q.rxst <= RX_IDLE;
        end else begin
            q <= d;
        end
    end

    assign wb_dat_o     = q.rdat;
    assign wb_ack_o     = q.ack;
    assign tx_req_valid = q.txv;
    assign tx_req_buf   = q.txbuf;
    assign dma_req      = q.dreq;
    assign dma_buf      = q.dbuf;
    assign dma_hit      = q.dhit;
    assign dma_addr     = {q.dbuf, 3'b000};

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    logic [7:0] req_vec;
    always_comb
        for (int i = 0; i < `CAR_NUM_TXB; i++)
            req_vec[i] = q.txb[i].req;

    sequence s_cmp_hit;
        q.rxst == RX_CMP && hit;
    endsequence

    property p_abort;
        q.abort && !q.busy && !bus_req && q.rxst != RX_CMP
            |=> req_vec == 8'h00;
    endproperty
    a_abort: assert property (p_abort) else $error("abort left request");

    property p_inflight;
        q.busy && !tx_done |=> q.txb[$past(q.busy_buf)].req;
    endproperty
    a_inflight: assert property (p_inflight) else $error("in-flight dropped");

    property p_done;
        tx_done && q.busy && !(q.rxst == RX_CMP && hit && auto_rep)
            && !bus_req |=> !q.txb[$past(q.busy_buf)].req && !q.busy;
    endproperty
    a_done: assert property (p_done) else $error("request not cleared");

    property p_auto;
        s_cmp_hit ##0 auto_rep |=> q.txb[$past(ptr[2:0])].req && !q.dreq;
    endproperty
    a_auto: assert property (p_auto) else $error("no auto reply");

    property p_dma;
        s_cmp_hit ##0 !to_txb |=> q.dreq && q.dbuf == $past(ptr)
            && q.dhit == $past(idx) ##1 q.dreq || $past(dma_ack);
    endproperty
    a_dma: assert property (p_dma) else $error("dma request wrong");

    property p_drop;
        q.rxst == RX_CMP && !hit |=> q.rxst == RX_IDLE && !q.dreq;
    endproperty
    a_drop: assert property (p_drop) else $error("unmatched kept");

    property p_fen;
        s_cmp_hit |-> q.fen[idx];
    endproperty
    a_fen: assert property (p_fen) else $error("disabled filter hit");

    property p_txsel;
        $rose(q.dreq) |-> q.dbuf[3] || !q.txb[q.dbuf[2:0]].txsel
            || $past(bus_req);
    endproperty
    a_txsel: assert property (p_txsel) else $error("dma to tx buffer");

    property p_ack;
        bus_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack timing");
endmodule
`default_nettype wire

/* File: dv/car_engine_model.sv */
// Protocol engine stand-in: delivers frames, sends queued buffers, acks DMA
`timescale 1ns/1ps
`default_nettype none
module car_engine_model #(
    parameter int ACK_DLY = 2,
    parameter int TX_LEN  = 6
) (
    input  wire logic          clock,
    input  wire logic          dma_req,
    input  wire logic          tx_req_valid,
    input  wire logic [2:0]    tx_req_buf,
    output logic               rx_valid,
    output car_pkg::car_frame_t rx_frame,
    output logic               dma_ack,
    output logic               tx_start,
    output logic [2:0]         tx_start_buf,
    output logic               tx_done
);
    import car_pkg::*;
    logic tx_en;
    int   cnt;
    int   txc;
    initial begin
        {rx_valid, dma_ack, tx_start, tx_done, tx_en} = '0;
        rx_frame = '0;
        tx_start_buf = '0;
        cnt = 0;
        txc = 0;
    end
    // Ack only after the request has stood ACK_DLY cycles
    always @(posedge clock) begin
        cnt <= (dma_req && !dma_ack) ? cnt + 1 : 0;
        dma_ack <= dma_req && !dma_ack && cnt >= ACK_DLY;
    end
    // Start a queued buffer, finish after TX_LEN, then hold off a while
    always @(posedge clock) begin
        tx_start <= 1'b0;
        tx_done <= 1'b0;
        if (txc == 0 && tx_en && tx_req_valid) begin
            tx_start <= 1'b1;
            tx_start_buf <= tx_req_buf;
            txc <= 1;
        end else if (txc == TX_LEN) begin
            tx_done <= 1'b1;
            txc <= -4;
        end else if (txc != 0) begin
            txc <= txc + 1;
        end
    end
    // Released identifier lines show the inverse, not the last frame
    task automatic send(input car_frame_t f);
        @(posedge clock);
        rx_valid <= 1'b1;
        rx_frame <= f;
        @(posedge clock);
        rx_valid <= 1'b0;
        rx_frame <= ~f;
    endtask
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the abort, remote reply and filter block
`timescale 1ns/1ps
`default_nettype none
`include "car_defines.svh"
module testbench;
    import car_pkg::*;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = '0;
    logic [31:0] wdat = '0;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic        ack, rxv, txs, txd, txv, dreq, dack;
    logic [2:0]  txsb, txb;
    logic [3:0]  dbuf, dhit;
    logic [6:0]  daddr;
    car_frame_t  rxf;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    car_core car_core_inst (.clock(clock), .sys_rst(sys_rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .rx_valid(rxv), .rx_frame(rxf), .tx_start(txs),
        .tx_start_buf(txsb), .tx_done(txd), .tx_req_valid(txv),
        .tx_req_buf(txb), .dma_req(dreq), .dma_buf(dbuf), .dma_hit(dhit),
        .dma_addr(daddr), .dma_ack(dack));
    car_engine_model #(.ACK_DLY(2), .TX_LEN(24)) model_inst (
        .clock(clock), .dma_req(dreq), .tx_req_valid(txv),
        .tx_req_buf(txb), .rx_valid(rxv), .rx_frame(rxf), .dma_ack(dack),
        .tx_start(txs), .tx_start_buf(txsb), .tx_done(txd));

    initial begin
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Classic cycle: hold everything until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clock); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, '0);
        chk(rd, e);
    endtask
    // Deliver a frame and judge whether and where DMA is requested
    task automatic rx(input car_frame_t f, input logic hit,
                      input logic [6:0] a, input logic [3:0] h);
        logic seen;
        seen = 1'b0;
        model_inst.send(f);
        repeat (5) begin
            @(posedge clock);
            if (dreq === 1'b1 && !seen) begin
                seen = 1'b1;
                chk({dbuf, dhit, daddr}, {a[6:3], h, a});
            end
        end
        chk(seen, hit);
        repeat (6) @(posedge clock);
    endtask

    task automatic t_regs();
        rdchk(`CAR_OFS_FEN, 32'h0);
        wr(`CAR_OFS_FEN, 32'h0009);
        rdchk(`CAR_OFS_FEN, 32'h0009);
        rdchk(8'h14, 32'h0);
    endtask
    task automatic t_filter();
        wr(`CAR_OFS_MSID, 32'h7ff);
        wr(`CAR_OFS_MEID, 32'h3ffff);
        wr(`CAR_OFS_FSID + 8'h0c, 32'h2a5);
        wr(`CAR_OFS_FEID + 8'h0c, 32'h15a5a);
        wr(`CAR_OFS_FSID, 32'h123);
        wr(`CAR_OFS_PTR, 32'ha002);
        rx('{11'h2a5, 18'h15a5a, 1'b1, 1'b0}, 1'b1, 7'h50, 4'd3);
        rx('{11'h2a5, 18'h15a5b, 1'b1, 1'b0}, 1'b0, 7'h0, 4'd0);
        rx('{11'h2a5, 18'h00000, 1'b0, 1'b0}, 1'b1, 7'h50, 4'd3);
        wr(`CAR_OFS_MEID, 32'h0);
        rx('{11'h2a5, 18'h00001, 1'b1, 1'b0}, 1'b1, 7'h50, 4'd3);
        wr(`CAR_OFS_FEN, 32'h0001);
        rx('{11'h2a5, 18'h15a5a, 1'b1, 1'b0}, 1'b0, 7'h0, 4'd0);
        wr(`CAR_OFS_FEN, 32'h0009);
        wr(`CAR_OFS_PTR, 32'hf002);
        rx('{11'h2a5, 18'h15a5a, 1'b1, 1'b0}, 1'b1, 7'h78, 4'd3);
    endtask
    // Second frame arrives while the first waits for DMA
    task automatic t_ovr();
        model_inst.send('{11'h2a5, 18'h15a5a, 1'b1, 1'b0});
        model_inst.send('{11'h2a5, 18'h15a5a, 1'b1, 1'b0});
        repeat (12) @(posedge clock);
        rdchk(`CAR_OFS_STAT, 32'h2000);
        wr(`CAR_OFS_STAT, 32'h2000);
        rdchk(`CAR_OFS_STAT, 32'h0);
    endtask
    task automatic t_remote();
        wr(`CAR_OFS_TXB + 8'h08, 32'h87);
        rx('{11'h123, 18'h0, 1'b0, 1'b1}, 1'b0, 7'h0, 4'd0);
        chk({txv, txb}, {1'b1, 3'd2});
        rdchk(`CAR_OFS_TXB + 8'h08, 32'h8f);
        wr(`CAR_OFS_TXB + 8'h10, 32'h88);
        repeat (3) @(posedge clock);
        chk({txv, txb}, {1'b1, 3'd2});
        wr(`CAR_OFS_CTRL, 32'h1000);
        repeat (4) @(posedge clock);
        chk(txv, 1'b0);
        rdchk(`CAR_OFS_TXB + 8'h08, 32'h87);
        rdchk(`CAR_OFS_TXB + 8'h10, 32'h80);
        rx('{11'h123, 18'h0, 1'b0, 1'b0}, 1'b0, 7'h0, 4'd0);
        chk(txv, 1'b0);
        wr(`CAR_OFS_TXB + 8'h04, 32'h84);
        wr(`CAR_OFS_PTR, 32'ha009);
        rx('{11'h123, 18'h0, 1'b0, 1'b1}, 1'b1, 7'h48, 4'd0);
        chk(txv, 1'b0);
        wr(`CAR_OFS_TXB + 8'h04, 32'h88);
        wr(`CAR_OFS_TXB + 8'h10, 32'h88);
        repeat (3) @(posedge clock);
        chk({txv, txb}, {1'b1, 3'd4});
        wr(`CAR_OFS_TXB + 8'h10, 32'h80);
        repeat (3) @(posedge clock);
        chk({txv, txb}, {1'b1, 3'd1});
        wr(`CAR_OFS_TXB + 8'h04, 32'h80);
        repeat (3) @(posedge clock);
        chk(txv, 1'b0);
    endtask
    task automatic t_inflight();
        model_inst.tx_en <= 1'b1;
        wr(`CAR_OFS_TXB + 8'h14, 32'h8b);
        repeat (4) @(posedge clock);
        wr(`CAR_OFS_CTRL, 32'h1000);
        wb(1'b0, `CAR_OFS_STAT, '0);
        chk(rd[11:8], 4'hd);
        wr(`CAR_OFS_TXB + 8'h14, 32'h83);
        rdchk(`CAR_OFS_TXB + 8'h14, 32'h8b);
        rdchk(`CAR_OFS_CTRL, 32'h1000);
        repeat (30) @(posedge clock);
        rdchk(`CAR_OFS_TXB + 8'h14, 32'h83);
        chk(txv, 1'b0);
        rdchk(`CAR_OFS_CTRL, 32'h0);
    endtask

    initial begin
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        t_regs();
        t_filter();
        t_ovr();
        t_remote();
        t_inflight();
        give_verdict();
    end
endmodule
`default_nettype wire
